// File: hw/rtsc_pkg.sv
package rtsc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_REF_TEMP_CONTROL = 5'h00;
   localparam logic [4:0] OFS_ADC_CONTROL      = 5'h04;
   localparam logic [4:0] OFS_RESULT_HIGH      = 5'h08;
   localparam logic [4:0] OFS_RESULT_LOW       = 5'h0c;
   localparam logic [4:0] OFS_IRQ_STATUS       = 5'h10;
   localparam logic [4:0] OFS_IRQ_MASK         = 5'h14;
   localparam logic [4:0] OFS_STATUS           = 5'h18;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_REF_ENABLE        = 7;
   localparam int BIT_REF_READY_FLAG    = 6;
   localparam int BIT_TEMP_SENSE_ENABLE = 5;
   localparam int BIT_TEMP_RANGE_SELECT = 4;
   localparam int BIT_GAIN_HI           = 1;
   localparam int BIT_GAIN_LO           = 0;
   localparam int BIT_ADC_ON            = 0;
   localparam int BIT_ADC_GO            = 1;
   localparam int BIT_ADC_REF_INTERNAL  = 2;
   localparam int BIT_CHAN_LO           = 8;
   localparam int BIT_CHAN_HI           = 12;
   localparam int BIT_IRQ_CONV_DONE     = 0;
   localparam int BIT_IRQ_REF_READY     = 1;
   localparam int BIT_STAT_TEMP_SETTLED = 0;
   localparam int BIT_STAT_BUSY         = 1;

   // ----------------------------------------------------------------
   // Reset values and codes
   // ----------------------------------------------------------------
   localparam logic [1:0] GAIN_OFF           = 2'h0;
   localparam logic [1:0] GAIN_1X            = 2'h1;
   localparam logic [1:0] GAIN_2X            = 2'h2;
   localparam logic [1:0] GAIN_4X            = 2'h3;
   localparam logic [4:0] CHAN_TEMP_SENSE    = 5'h1d;
   localparam logic [4:0] CHAN_FIXED_REF     = 5'h1e;
   localparam logic [4:0] CHAN_RESET         = 5'h00;
   localparam logic [1:0] IRQ_RESET          = 2'h0;

   // ----------------------------------------------------------------
   // Timing and result width
   // ----------------------------------------------------------------
   localparam int CLK_MHZ            = 250;
   localparam int TEMP_SETTLE_US     = 200;
   localparam int TEMP_SETTLE_CYC    = TEMP_SETTLE_US * CLK_MHZ;
   localparam int SAMPLE_CYC         = 8;
   localparam int RESULT_WIDTH       = 10;

endpackage : rtsc_pkg

// File: hw/rtsc_sar.sv
`timescale 1ns/10ps
module rtsc_sar
   import rtsc_pkg::*;
#(
   parameter int WIDTH      = RESULT_WIDTH,
   parameter int SAMPLE_LEN = SAMPLE_CYC
)
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_sys_rst,
   input  wire logic             i_clk_en,
   input  wire logic             i_start,
   input  wire logic             i_abort,
   input  wire logic             i_comparator,
   output logic                  o_busy,
   output logic                  o_sample,
   output logic [WIDTH-1:0]      o_trial_code,
   output logic [WIDTH-1:0]      o_result,
   output logic                  o_done
);

   localparam int SCW = $clog2(SAMPLE_LEN + 1);

   typedef enum logic [1:0]
   {
      SAR_IDLE    = 2'b00,
      SAR_SAMPLE  = 2'b01,
      SAR_CONVERT = 2'b10
   } rtsc_sar_state_t;

   typedef struct packed
   {
      rtsc_sar_state_t  st;
      logic [SCW-1:0]   cnt;
      logic [WIDTH-1:0] code;
      logic [WIDTH-1:0] mask;
      logic [WIDTH-1:0] result;
      logic             done;
   } rtsc_sar_regs_t;

   rtsc_sar_regs_t r;
   rtsc_sar_regs_t next_r;

   // ----------------------------------------------------------------
   // Sample, then one trial bit per cycle from the top down
   // ----------------------------------------------------------------
   always_comb
   begin
      logic last_bit;
      last_bit = 1'b0;
      next_r      = r;
      next_r.done = 1'b0;
      case (r.st)
         SAR_IDLE:
         begin
            if (i_start)
            begin
               next_r.st  = SAR_SAMPLE;
               next_r.cnt = '0;
            end
         end
         SAR_SAMPLE:
         begin
            if (i_abort)
            begin
               next_r.st = SAR_IDLE;
            end
            else if (r.cnt == SCW'(SAMPLE_LEN - 1))
            begin
               next_r.st   = SAR_CONVERT;
               next_r.mask = {1'b1, {(WIDTH-1){1'b0}}};
               next_r.code = {1'b1, {(WIDTH-1){1'b0}}};
            end
            else
            begin
               next_r.cnt = r.cnt + SCW'(1);
            end
         end
         SAR_CONVERT:
         begin
            if (i_abort)
            begin
               // Undecided bits copy the last decided bit
               last_bit = (r.mask[WIDTH-1]) ? 1'b0 : |(r.code & (r.mask << 1));
               for (int i = 0; i < WIDTH; i++)
               begin
                  if (r.mask >= (WIDTH'(1) << i))
                  begin
                     next_r.result[i] = last_bit;
                  end
                  else
                  begin
                     next_r.result[i] = r.code[i];
                  end
               end
               next_r.st = SAR_IDLE;
            end
            else
            begin
               next_r.code = (i_comparator) ? r.code : (r.code & ~r.mask);
               next_r.mask = r.mask >> 1;
               next_r.code = next_r.code | (r.mask >> 1);
               if (r.mask[0])
               begin
                  next_r.result = (i_comparator) ? r.code : (r.code & ~r.mask);
                  next_r.done   = 1'b1;
                  next_r.st     = SAR_IDLE;
               end
            end
         end
         default:
         begin
            next_r.st = SAR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         r <= '0;
      end
      else if (i_clk_en)
      begin
         r <= next_r;
      end
   end

   assign o_busy       = (r.st != SAR_IDLE);
   assign o_sample     = (r.st == SAR_SAMPLE);
   assign o_trial_code = r.code;
   assign o_result     = r.result;
   assign o_done       = r.done;

endmodule : rtsc_sar

// File: hw/rtsc_top.sv
`timescale 1ns/10ps
module rtsc_top
   import rtsc_pkg::*;
#(
   parameter int TEMP_SETTLE_CYCLES = TEMP_SETTLE_CYC,
   parameter int SAMPLE_CYCLES      = SAMPLE_CYC
)
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_sys_rst,
   input  wire logic                    i_clk_en,
   // Avalon-MM slave
   input  wire logic [4:0]              i_avs_address,
   input  wire logic                    i_avs_read,
   input  wire logic                    i_avs_write,
   input  wire logic [31:0]             i_avs_writedata,
   input  wire logic [3:0]              i_avs_byteenable,
   output logic      [31:0]             o_avs_readdata,
   output logic                         o_avs_waitrequest,
   // Analog side
   input  wire logic                    i_ref_output_ok,
   input  wire logic                    i_comparator,
   input  wire logic                    i_sleep,
   output logic                         o_ref_enable,
   output logic                         o_temp_sense_enable,
   output logic                         o_temp_range_select,
   output logic      [1:0]              o_adc_ref_gain_select,
   output logic                         o_adc_ref_internal,
   output logic      [4:0]              o_adc_channel,
   output logic                         o_sample_hold,
   output logic      [RESULT_WIDTH-1:0] o_sar_trial_code,
   // Interrupt
   output logic                         o_irq,
   output logic                         o_wake
);

   localparam int CW = $clog2(TEMP_SETTLE_CYCLES + 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic        ref_enable;
      logic        temp_sense_enable;
      logic        temp_range_select;
      logic [1:0]  adc_ref_gain_select;
      logic        ref_ready_flag;
      logic        adc_on;
      logic        ref_internal;
      logic [4:0]  channel;
      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic        ack;
      logic [31:0] rdata;
      logic [CW-1:0] settle_cnt;
      logic        start;
      logic        abort;
   } rtsc_regs_t;

   rtsc_regs_t r;
   rtsc_regs_t next_r;

   logic                    sar_busy;
   logic                    sar_done;
   logic [RESULT_WIDTH-1:0] sar_result;
   logic                    req;
   logic                    wr_hit;
   logic                    temp_settled;

   function automatic logic wr_at(input logic [4:0] ofs);
      wr_at = wr_hit && (i_avs_address == ofs);
   endfunction : wr_at

   assign req          = i_avs_read | i_avs_write;
   assign wr_hit       = i_avs_write && !r.ack;
   assign temp_settled = (r.settle_cnt == CW'(TEMP_SETTLE_CYCLES));

   // ----------------------------------------------------------------
   // Converter engine
   // ----------------------------------------------------------------
   rtsc_sar #(
      .WIDTH        (RESULT_WIDTH),
      .SAMPLE_LEN   (SAMPLE_CYCLES)
   ) u_sar (
      .i_clk_sys    (i_clk_sys),
      .i_sys_rst    (i_sys_rst),
      .i_clk_en     (i_clk_en),
      .i_start      (r.start),
      .i_abort      (r.abort),
      .i_comparator (i_comparator),
      .o_busy       (sar_busy),
      .o_sample     (o_sample_hold),
      .o_trial_code (o_sar_trial_code),
      .o_result     (sar_result),
      .o_done       (sar_done)
   );

   // ----------------------------------------------------------------
   // Register file and control
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] b0;
      logic [1:0] irq_set;
      b0          = i_avs_writedata[7:0];
      irq_set     = 2'b00;
      next_r      = r;
      next_r.start = 1'b0;
      next_r.abort = 1'b0;
      next_r.ack  = req && !r.ack;

      // Ready only while enabled; disabling drops it one cycle after the enable clears
      next_r.ref_ready_flag = r.ref_enable && i_ref_output_ok;

      if (wr_at(OFS_REF_TEMP_CONTROL) && i_avs_byteenable[0])
      begin
         next_r.ref_enable          = b0[BIT_REF_ENABLE];
         next_r.temp_sense_enable   = b0[BIT_TEMP_SENSE_ENABLE];
         next_r.temp_range_select   = b0[BIT_TEMP_RANGE_SELECT];
         next_r.adc_ref_gain_select = b0[BIT_GAIN_HI:BIT_GAIN_LO];
         // Bits 3:2 have no storage at all
      end

      if (wr_at(OFS_ADC_CONTROL))
      begin
         if (i_avs_byteenable[0])
         begin
            next_r.adc_on       = b0[BIT_ADC_ON];
            next_r.ref_internal = b0[BIT_ADC_REF_INTERNAL];
            // Go needs the converter already on, not switched on in the same write
            if (b0[BIT_ADC_GO] && r.adc_on && !sar_busy)
            begin
               next_r.start = 1'b1;
            end
            if ((!b0[BIT_ADC_GO] || !b0[BIT_ADC_ON]) && sar_busy)
            begin
               next_r.abort = 1'b1;
            end
         end
         if (i_avs_byteenable[1])
         begin
            next_r.channel = i_avs_writedata[BIT_CHAN_HI:BIT_CHAN_LO];
         end
      end

      if (wr_at(OFS_IRQ_MASK) && i_avs_byteenable[0])
      begin
         next_r.irq_mask = b0[1:0];
      end

      // Settling timer: restarts on entry to the temperature channel and after each of its completed conversions
      if (!(r.channel == CHAN_TEMP_SENSE) || !r.temp_sense_enable)
      begin
         next_r.settle_cnt = '0;
      end
      else if (sar_done)
      begin
         next_r.settle_cnt = '0;
      end
      else if (!temp_settled)
      begin
         next_r.settle_cnt = r.settle_cnt + CW'(1);
      end

      // Sticky events; a read clears, but a new event in that cycle survives
      irq_set[BIT_IRQ_CONV_DONE] = sar_done;
      irq_set[BIT_IRQ_REF_READY] = next_r.ref_ready_flag && !r.ref_ready_flag;
      if (i_avs_read && !r.ack && (i_avs_address == OFS_IRQ_STATUS))
      begin
         next_r.irq_status = irq_set;
      end
      else
      begin
         next_r.irq_status = r.irq_status | irq_set;
      end

      if (i_avs_read && !r.ack)
      begin
         next_r.rdata = 32'h0000_0000;
         case (i_avs_address)
            OFS_REF_TEMP_CONTROL:
            begin
               next_r.rdata[BIT_REF_ENABLE]          = r.ref_enable;
               // The flag lags the enable by a cycle, so gate it here as well
               next_r.rdata[BIT_REF_READY_FLAG]      = r.ref_ready_flag && r.ref_enable;
               next_r.rdata[BIT_TEMP_SENSE_ENABLE]   = r.temp_sense_enable;
               next_r.rdata[BIT_TEMP_RANGE_SELECT]   = r.temp_range_select;
               next_r.rdata[BIT_GAIN_HI:BIT_GAIN_LO] = r.adc_ref_gain_select;
            end
            OFS_ADC_CONTROL:
            begin
               next_r.rdata[BIT_ADC_ON]                 = r.adc_on;
               next_r.rdata[BIT_ADC_GO]                 = sar_busy;
               next_r.rdata[BIT_ADC_REF_INTERNAL]       = r.ref_internal;
               next_r.rdata[BIT_CHAN_HI:BIT_CHAN_LO]    = r.channel;
            end
            OFS_RESULT_HIGH:
            begin
               next_r.rdata[RESULT_WIDTH-9:0] = sar_result[RESULT_WIDTH-1:8];
            end
            OFS_RESULT_LOW:
            begin
               next_r.rdata[7:0] = sar_result[7:0];
            end
            OFS_IRQ_STATUS:
            begin
               next_r.rdata[1:0] = r.irq_status;
            end
            OFS_IRQ_MASK:
            begin
               next_r.rdata[1:0] = r.irq_mask;
            end
            OFS_STATUS:
            begin
               next_r.rdata[BIT_STAT_TEMP_SETTLED] = temp_settled;
               next_r.rdata[BIT_STAT_BUSY]         = sar_busy;
            end
            default:
            begin
               next_r.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         r            <= '0;
         r.channel    <= CHAN_RESET;
         r.irq_status <= IRQ_RESET;
         r.irq_mask   <= IRQ_RESET;
         r.adc_ref_gain_select <= GAIN_OFF;
      end
      else if (i_clk_en)
      begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_avs_waitrequest     = req && !r.ack;
   assign o_avs_readdata        = r.rdata;
   assign o_ref_enable          = r.ref_enable;
   assign o_temp_sense_enable   = r.temp_sense_enable;
   assign o_temp_range_select   = r.temp_range_select;
   assign o_adc_ref_gain_select = r.adc_ref_gain_select;
   assign o_adc_ref_internal    = r.ref_internal;
   assign o_adc_channel         = r.channel;
   assign o_irq                 = |(r.irq_status & r.irq_mask);
   // Wake needs no clock, so the converter may finish while the core sleeps
   assign o_wake                = i_sleep && r.irq_status[BIT_IRQ_CONV_DONE] && r.irq_mask[BIT_IRQ_CONV_DONE];

endmodule : rtsc_top

// File: test/ref_temp_sense_control_test.sv
`timescale 1ns/10ps
module ref_temp_sense_control_test;
   import rtsc_pkg::*;
   logic        i_clk_sys, i_sys_rst, i_clk_en, i_avs_read, i_avs_write;
   logic        i_ref_output_ok, i_sleep, i_comparator;
   logic [4:0]  i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, q, d;
   logic [3:0]  i_avs_byteenable;
   logic        o_avs_waitrequest, o_ref_enable, o_temp_sense_enable, o_temp_range_select;
   logic        o_adc_ref_internal, o_sample_hold, o_irq, o_wake;
   logic [1:0]  o_adc_ref_gain_select;
   logic [4:0]  o_adc_channel;
   logic [9:0]  o_sar_trial_code, target;
   int          err_count, total_checks, seed, i, n;

   rtsc_top #(.TEMP_SETTLE_CYCLES(20), .SAMPLE_CYCLES(4)) dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_ref_output_ok(i_ref_output_ok), .i_comparator(i_comparator),
      .i_sleep(i_sleep), .o_ref_enable(o_ref_enable), .o_temp_sense_enable(o_temp_sense_enable),
      .o_temp_range_select(o_temp_range_select), .o_adc_ref_gain_select(o_adc_ref_gain_select),
      .o_adc_ref_internal(o_adc_ref_internal), .o_adc_channel(o_adc_channel), .o_sample_hold(o_sample_hold),
      .o_sar_trial_code(o_sar_trial_code), .o_irq(o_irq), .o_wake(o_wake));

   // Analog input modelled as a fixed level against the trial code
   assign i_comparator = (target >= o_sar_trial_code);

   initial
   begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Request held until waitrequest is sampled low at a rising edge; read data is taken at that edge
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
      int k;
      @(posedge i_clk_sys);
      i_avs_read      <= !wr;
      i_avs_write     <= wr;
      i_avs_address   <= a;
      i_avs_writedata <= dat;
      k = 0;
      do
      begin
         @(posedge i_clk_sys);
         k++;
      end
      while (o_avs_waitrequest !== 1'b0 && k < 20);
      if (k >= 20)
      begin
         err_count++;
         give_verdict();
      end
      else
      begin
         q = o_avs_readdata;
         i_avs_read  <= 1'b0;
         i_avs_write <= 1'b0;
      end
   endtask : bus
   task rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rdchk
   function logic [31:0] ctrl_exp(input logic [7:0] v, input logic ok);
      return {24'h0, v[7], v[7] & ok, v[5:4], 2'h0, v[1:0]};
   endfunction : ctrl_exp
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {i_avs_read, i_avs_write, i_ref_output_ok, i_sleep, i_avs_address, i_avs_writedata} = '0;
      i_clk_en = 1'b1;
      i_avs_byteenable = 4'hf;
      target = 10'h0;
      err_count = 0;
      total_checks = 0;
      seed = 32'hb383;
      i_sys_rst = 1'b1;
      repeat (3) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      rdchk(OFS_REF_TEMP_CONTROL, 32'h0);
      rdchk(5'h1c, 32'h0);
      for (i = 0; i < 12; i++)
      begin
         d = $random(seed);
         if (i < 4)
            d[1:0] = 2'(i);
         i_ref_output_ok <= d[8];
         bus(1'b1, OFS_REF_TEMP_CONTROL, d);
         check(32'({o_ref_enable, o_temp_sense_enable, o_temp_range_select, o_adc_ref_gain_select}),
               32'({d[7], d[5:4], d[1:0]}));
         rdchk(OFS_REF_TEMP_CONTROL, ctrl_exp(d[7:0], d[8]));
      end
      $display("control test done");
      // Second reset in mid-run must bring every control field back to zero
      @(posedge i_clk_sys);
      i_sys_rst <= 1'b1;
      @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      rdchk(OFS_REF_TEMP_CONTROL, 32'h0);
      check(32'({o_temp_sense_enable, o_temp_range_select, o_adc_ref_gain_select}), 32'h0);
      bus(1'b1, OFS_REF_TEMP_CONTROL, 32'h20);
      bus(1'b1, OFS_ADC_CONTROL, {19'h0, CHAN_TEMP_SENSE, 8'h05});
      check(32'({o_adc_channel, o_adc_ref_internal}), 32'({CHAN_TEMP_SENSE, 1'b1}));
      rdchk(OFS_STATUS, 32'h0);
      repeat (25) @(posedge i_clk_sys);
      rdchk(OFS_STATUS, 32'h1);
      for (i = 0; i < 5; i++)
      begin
         target <= (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($random(seed));
         i_sleep <= (i == 3);
         bus(1'b1, OFS_IRQ_MASK, 32'(i != 2));
         bus(1'b1, OFS_ADC_CONTROL, {19'h0, CHAN_TEMP_SENSE, 8'h07});
         n = 0;
         while (o_sample_hold !== 1'b1 && n < 10)
         begin
            @(negedge i_clk_sys);
            n++;
         end
         check(32'(o_sample_hold), 32'h1);
         do
         begin
            bus(1'b0, OFS_STATUS, 32'h0);
            n++;
         end
         while (q[1] !== 1'b0 && n < 30);
         check(32'(q[1]), 32'h0);
         check(32'(o_irq), 32'(i != 2));
         check(32'(o_wake), 32'(i == 3));
         rdchk(OFS_STATUS, 32'h0);
         rdchk(OFS_RESULT_HIGH, 32'(target[9:8]));
         rdchk(OFS_RESULT_LOW, 32'(target[7:0]));
         rdchk(OFS_IRQ_STATUS, 32'h1);
         check(32'(o_irq), 32'h0);
         rdchk(OFS_IRQ_STATUS, 32'h0);
         repeat (25) @(posedge i_clk_sys);
      end
      $display("conversion test done");
      give_verdict();
   end
endmodule : ref_temp_sense_control_test

// File: test/rtsc_assertions.sv
`timescale 1ns/10ps
module rtsc_checker
   import rtsc_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_sys_rst,
   input wire logic        i_clk_en,
   input wire logic [4:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_sleep,
   input wire logic        o_ref_enable,
   input wire logic        o_temp_sense_enable,
   input wire logic        o_temp_range_select,
   input wire logic [1:0]  o_adc_ref_gain_select,
   input wire logic        o_adc_ref_internal,
   input wire logic [4:0]  o_adc_channel,
   input wire logic        o_sample_hold,
   input wire logic        o_irq,
   input wire logic        o_wake
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // ----------------------------------------------------------------
   // Bus events
   // ----------------------------------------------------------------
   logic take_w;
   logic take_ctl;
   logic take_adc;
   logic ans_ctl;
   assign take_w   = i_avs_write & o_avs_waitrequest & i_clk_en;
   assign take_ctl = take_w & (i_avs_address == OFS_REF_TEMP_CONTROL) & i_avs_byteenable[0];
   assign take_adc = take_w & (i_avs_address == OFS_ADC_CONTROL) & (i_avs_byteenable == 4'hf);
   assign ans_ctl  = i_avs_read & ~o_avs_waitrequest & (i_avs_address == OFS_REF_TEMP_CONTROL);
   // Sampling window opens on the rising edge and lasts four cycles, the sample count the testbench sets
   sequence s_sample;
      $rose(o_sample_hold) ##0 o_sample_hold [*4];
   endsequence
   property p_wait;
      (i_avs_read | i_avs_write) & o_avs_waitrequest & i_clk_en |=> !o_avs_waitrequest;
   endproperty
   property p_sense;
      take_ctl |=> o_temp_sense_enable == $past(i_avs_writedata[5])
                   && o_temp_range_select == $past(i_avs_writedata[4]);
   endproperty
   property p_gain;
      take_ctl |=> o_adc_ref_gain_select == $past(i_avs_writedata[1:0]);
   endproperty
   property p_refen;
      take_ctl |=> o_ref_enable == $past(i_avs_writedata[7]);
   endproperty
   property p_unused;
      ans_ctl |-> o_avs_readdata[3:2] == 2'h0 && o_avs_readdata[31:8] == 24'h0;
   endproperty
   property p_ready;
      ans_ctl && o_avs_readdata[6] |-> o_avs_readdata[7];
   endproperty
   property p_chan;
      take_adc |=> o_adc_channel == $past(i_avs_writedata[12:8])
                   && o_adc_ref_internal == $past(i_avs_writedata[2]);
   endproperty
   property p_wake;
      o_wake |-> i_sleep && o_irq;
   endproperty
   property p_sample;
      s_sample |=> !o_sample_hold;
   endproperty
   a_wait   : assert property (p_wait)   else $error("waitrequest not low one cycle after request");
   a_sense  : assert property (p_sense)  else $error("sensor enable or range not as written");
   a_gain   : assert property (p_gain)   else $error("reference gain not as written");
   a_refen  : assert property (p_refen)  else $error("reference enable not as written");
   a_unused : assert property (p_unused) else $error("unused control bits read nonzero");
   a_ready  : assert property (p_ready)  else $error("ready flag set with reference off");
   a_chan   : assert property (p_chan)   else $error("channel or reference source not as written");
   a_wake   : assert property (p_wake)   else $error("wake without sleep and pending interrupt");
   a_sample : assert property (p_sample) else $error("sample window length wrong");
endmodule : rtsc_checker

bind rtsc_top rtsc_checker u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_sleep(i_sleep), .o_ref_enable(o_ref_enable),
   .o_temp_sense_enable(o_temp_sense_enable), .o_temp_range_select(o_temp_range_select),
   .o_adc_ref_gain_select(o_adc_ref_gain_select), .o_adc_ref_internal(o_adc_ref_internal),
   .o_adc_channel(o_adc_channel), .o_sample_hold(o_sample_hold), .o_irq(o_irq), .o_wake(o_wake));
